// *** inc/mdsr_pkg.sv ***
// Constants for the motor drive shift and rotor sensing control block
package mdsr_pkg;
    // Register addresses on the serial register port
    localparam logic [7:0] PHASE_SHIFT_ADDR  = 8'h10;
    localparam logic [7:0] SINE_DRIVE_ADDR   = 8'h11;
    localparam logic [7:0] ROTOR_SENSOR_ADDR = 8'h12;
    localparam logic [7:0] PWM_MODE_ADDR     = 8'h13;
    localparam logic [7:0] DRIVE_STATUS_ADDR = 8'h14;
    // Reset values and writable-bit masks
    localparam logic [7:0] PHASE_SHIFT_RST   = 8'h00;
    localparam logic [7:0] SINE_DRIVE_RST    = 8'h00;
    localparam logic [7:0] ROTOR_SENSOR_RST  = 8'h00;
    localparam logic [7:0] PWM_MODE_RST      = 8'h00;
    localparam logic [7:0] SINE_DRIVE_MASK   = 8'hc0;
    localparam logic [7:0] ROTOR_SENSOR_MASK = 8'h0f;
    localparam logic [7:0] PWM_MODE_MASK     = 8'h81;
    // Field positions
    localparam int SHIFT_SRC_BIT   = 7;
    localparam int RANGE_LSB       = 5;
    localparam int SHIFT_LSB       = 0;
    localparam int FORCE_REQ_BIT   = 7;
    localparam int FORCE_SHAPE_BIT = 6;
    localparam int REG_EN_BIT      = 3;
    localparam int INV_LSB         = 0;
    localparam int SHAPE_SEL_BIT   = 7;
    localparam int MIN_DUTY_BIT    = 0;
    // Timing
    localparam int CLK_HZ       = 25_000_000;
    localparam int CLK_NS       = 40;
    localparam int DEBOUNCE_NS  = 3000;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWM_PER_NS   = 50000;
    localparam int PWM_PER_CYC  = PWM_PER_NS / CLK_NS;
    localparam int MIN_ON_NS    = 1000;
    localparam int MIN_ON_CYC   = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;
    // Predictor windows in tenths of a hertz
    localparam int R0_LO_DHZ = 8;
    localparam int R0_HI_DHZ = 800;
    localparam int R1_LO_DHZ = 4;
    localparam int R1_HI_DHZ = 400;
    localparam int R2_LO_DHZ = 32;
    localparam int R2_HI_DHZ = 3200;
    localparam logic [7:0]  ANGLE_MAX_DEG = 8'd58;
    localparam logic [4:0]  ANGLE_MAX_SET = 5'd31;
endpackage

// *** hw/mdsr_ctl.sv ***
// Shift, drive-shape and rotor sensor conditioning logic with its control registers
`timescale 1ns/10ps
//
// Contract
// - Low-side minimum-duty pulses on all phases while enabled and PWM output is off.
// - Range field picks predictor window: 0.8-80, 0.4-40 or 3.2-320 Hz.
// - Forced request 0: sine drive entered only when entry conditions hold.
// - Forced request 1: forced drive path enabled regardless of conditions.
// - Under forcing, shape bit 0 gives square PWM, 1 gives sine PWM.
// - Forced sine output only when request and shape bits are both 1.
// - Every rotor sensor input is always debounced against bounce shorter than 3 us (75 cycles).
// - Regulation enable bit switches an extra filter stage off or on.
// - Regulation rejects abnormal transitions and bridges gaps in sensor signals.
// - Each sensor input has its own inversion bit applied before processing.
// - Shape select bit: 0 sine, 1 square, after correct prediction.
module mdsr_ctl
    import mdsr_pkg::*;
#(
    parameter int R0_MAX_CYC = CLK_HZ / R0_LO_DHZ * 10,
    parameter int R0_MIN_CYC = CLK_HZ / R0_HI_DHZ * 10,
    parameter int R1_MAX_CYC = CLK_HZ / R1_LO_DHZ * 10,
    parameter int R1_MIN_CYC = CLK_HZ / R1_HI_DHZ * 10,
    parameter int R2_MAX_CYC = CLK_HZ / R2_LO_DHZ * 10,
    parameter int R2_MIN_CYC = CLK_HZ / R2_HI_DHZ * 10
) (
    input  wire logic       clk,                // System clock
    input  wire logic       sys_rst,            // Asynchronous reset
    input  wire logic       reg_wr,             // Register write strobe
    input  wire logic       reg_rd,             // Register read strobe
    input  wire logic [7:0] reg_addr,           // Register address
    input  wire logic [7:0] reg_wdata,          // Write data
    output logic      [7:0] reg_rdata,          // Read data
    input  wire logic       rotor_sensor_a,     // Rotor sensor A
    input  wire logic       rotor_sensor_b,     // Rotor sensor B
    input  wire logic       rotor_sensor_c,     // Rotor sensor C
    input  wire logic [4:0] shift_voltage_pin,  // Digitised shift pin level
    input  wire logic       pwm_output_enable,  // PWM output allowed
    input  wire logic       sine_entry_ok,      // Internal sine entry conditions
    input  wire logic [2:0] sq_pwm_hi,          // Square PWM high side
    input  wire logic [2:0] sq_pwm_lo,          // Square PWM low side
    input  wire logic [2:0] sine_pwm_hi,        // Sine PWM high side
    input  wire logic [2:0] sine_pwm_lo,        // Sine PWM low side
    output logic      [2:0] gate_hi,            // Gate drive high side
    output logic      [2:0] gate_lo,            // Gate drive low side
    output logic      [2:0] rotor_state,        // Conditioned sensor code
    output logic      [5:0] lead_angle,         // Lead angle in degrees
    output logic            predictor_in_range, // Sensor frequency in window
    output logic            drive_is_sine       // Sine drive selected
);

    function automatic logic [5:0] scale_angle(input logic [4:0] c);
        logic [10:0] p;
        p = {6'h00, c} * 11'(ANGLE_MAX_DEG);
        return 6'((p + 11'd15) / 11'({6'h00, ANGLE_MAX_SET}));
    endfunction

    function automatic logic adjacent(input logic [2:0] a, input logic [2:0] b);
        logic [2:0] x;
        x = a ^ b;
        return (x == 3'b001) || (x == 3'b010) || (x == 3'b100);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] phase_shift_q, sine_drive_q, rotor_sensor_q, pwm_mode_q;
    logic [7:0] rdata_d;
    logic       wr_shift, wr_sine, wr_sensor, wr_mode;
    logic [7:0] status_w;

    assign wr_shift  = reg_wr && (reg_addr == PHASE_SHIFT_ADDR);
    assign wr_sine   = reg_wr && (reg_addr == SINE_DRIVE_ADDR);
    assign wr_sensor = reg_wr && (reg_addr == ROTOR_SENSOR_ADDR);
    assign wr_mode   = reg_wr && (reg_addr == PWM_MODE_ADDR);
    assign status_w  = {drive_is_sine, predictor_in_range, 3'h0, rotor_state};
    assign rdata_d   = (reg_addr == PHASE_SHIFT_ADDR)  ? phase_shift_q  :
                       (reg_addr == SINE_DRIVE_ADDR)   ? sine_drive_q   :
                       (reg_addr == ROTOR_SENSOR_ADDR) ? rotor_sensor_q :
                       (reg_addr == PWM_MODE_ADDR)     ? pwm_mode_q     :
                       (reg_addr == DRIVE_STATUS_ADDR) ? status_w       : 8'h00;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_shift_q  <= PHASE_SHIFT_RST;
            sine_drive_q   <= SINE_DRIVE_RST;
            rotor_sensor_q <= ROTOR_SENSOR_RST;
            pwm_mode_q     <= PWM_MODE_RST;
            reg_rdata      <= 8'h00;
        end else begin
            if (wr_shift)  phase_shift_q  <= reg_wdata;
            if (wr_sine)   sine_drive_q   <= reg_wdata & SINE_DRIVE_MASK;
            if (wr_sensor) rotor_sensor_q <= reg_wdata & ROTOR_SENSOR_MASK;
            if (wr_mode)   pwm_mode_q     <= reg_wdata & PWM_MODE_MASK;
            if (reg_rd)    reg_rdata      <= rdata_d;
        end
    end

    logic       shift_src, force_req, force_shape, reg_en, shape_sel, min_duty_en;
    logic [1:0] range_sel;
    logic [4:0] shift_field;
    assign shift_src   = phase_shift_q[SHIFT_SRC_BIT];
    assign range_sel   = phase_shift_q[RANGE_LSB +: 2];
    assign shift_field = phase_shift_q[SHIFT_LSB +: 5];
    assign force_req   = sine_drive_q[FORCE_REQ_BIT];
    assign force_shape = sine_drive_q[FORCE_SHAPE_BIT];
    assign reg_en      = rotor_sensor_q[REG_EN_BIT];
    assign shape_sel   = pwm_mode_q[SHAPE_SEL_BIT];
    assign min_duty_en = pwm_mode_q[MIN_DUTY_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Rotor sensor conditioning
    logic [2:0] raw_w, deb_q;
    logic [7:0] deb_cnt_q [3];
    assign raw_w = {rotor_sensor_c, rotor_sensor_b, rotor_sensor_a}
                 ^ rotor_sensor_q[INV_LSB +: 3];

    for (genvar i = 0; i < 3; i++) begin : g_deb
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                deb_q[i]     <= 1'b0;
                deb_cnt_q[i] <= 8'h00;
            end else if (raw_w[i] == deb_q[i]) begin
                deb_cnt_q[i] <= 8'h00;
            end else if (deb_cnt_q[i] == 8'(DEBOUNCE_CYC - 1)) begin
                deb_q[i]     <= raw_w[i];
                deb_cnt_q[i] <= 8'h00;
            end else begin
                deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
            end
        end
    end

    // Regulation keeps the last good code over illegal codes and skipped steps
    logic       code_ok;
    logic [2:0] state_d;
    assign code_ok = (deb_q != 3'b000) && (deb_q != 3'b111) && adjacent(rotor_state, deb_q);
    assign state_d = !reg_en ? deb_q : (code_ok ? deb_q : rotor_state);

    ////////////////////////////////////////////////////////////////////////////
    // Sensor period and predictor window
    logic [25:0] per_cnt_q, per_q;
    logic        per_valid_q, edge_w;
    int          win_max, win_min;
    assign edge_w  = state_d[0] && !rotor_state[0];
    assign win_max = range_sel[1] ? R2_MAX_CYC : (range_sel[0] ? R1_MAX_CYC : R0_MAX_CYC);
    assign win_min = range_sel[1] ? R2_MIN_CYC : (range_sel[0] ? R1_MIN_CYC : R0_MIN_CYC);

    logic in_range_d, use_sine, forced_sine, auto_sine;
    assign in_range_d  = per_valid_q && (int'(per_q) >= win_min) && (int'(per_q) <= win_max)
                       && (int'(per_cnt_q) <= win_max);
    assign forced_sine = force_req && force_shape;
    assign auto_sine   = !force_req && sine_entry_ok && predictor_in_range && !shape_sel;
    assign use_sine    = force_req ? forced_sine : auto_sine;

    ////////////////////////////////////////////////////////////////////////////
    // Minimum-duty pulse and gate outputs
    logic [10:0] pwm_cnt_q;
    logic        min_pulse;
    logic [2:0]  hi_d, lo_d;
    assign min_pulse = pwm_cnt_q < 11'(MIN_ON_CYC);
    assign hi_d = pwm_output_enable ? (use_sine ? sine_pwm_hi : sq_pwm_hi) : 3'b000;
    assign lo_d = pwm_output_enable ? (use_sine ? sine_pwm_lo : sq_pwm_lo) :
                  (min_duty_en ? {3{min_pulse}} : 3'b000);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rotor_state        <= 3'b000;
            per_cnt_q          <= 26'h0000000;
            per_q              <= 26'h0000000;
            per_valid_q        <= 1'b0;
            predictor_in_range <= 1'b0;
            drive_is_sine      <= 1'b0;
            pwm_cnt_q          <= 11'h000;
            gate_hi            <= 3'b000;
            gate_lo            <= 3'b000;
            lead_angle         <= 6'h00;
        end else begin
            rotor_state        <= state_d;
            predictor_in_range <= in_range_d;
            drive_is_sine      <= use_sine;
            gate_hi            <= hi_d;
            gate_lo            <= lo_d;
            lead_angle         <= scale_angle(shift_src ? shift_field : shift_voltage_pin);
            pwm_cnt_q          <= (pwm_cnt_q == 11'(PWM_PER_CYC - 1)) ? 11'h000 : pwm_cnt_q + 11'h001;
            if (edge_w) begin
                per_q       <= per_cnt_q;
                per_cnt_q   <= 26'h0000001;
                per_valid_q <= 1'b1;
            end else if (per_cnt_q != 26'h3ffffff) begin
                per_cnt_q <= per_cnt_q + 26'h0000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_lowside_idle;
        !pwm_output_enable && min_duty_en;
    endsequence
    sequence s_pulse_start;
        s_lowside_idle ##0 (pwm_cnt_q == 11'h000);
    endsequence

    min_duty_pulse_a: assert property (s_pulse_start |=> gate_lo == 3'b111 && gate_hi == 3'b000)
        else $error("low side minimum pulse missing");
    min_duty_gap_a: assert property (s_lowside_idle ##0 !min_pulse |=> gate_lo == 3'b000)
        else $error("low side pulse too long");
    shift_pin_a: assert property (!shift_src |=> lead_angle == scale_angle($past(shift_voltage_pin)))
        else $error("shift not taken from pin");
    shift_full_a: assert property (shift_src && shift_field == 5'h1f |=> lead_angle == 6'd58)
        else $error("full shift not 58 degrees");
    range_slow_a: assert property (range_sel == 2'b00 && int'(per_q) > R0_MAX_CYC
                                   |=> !predictor_in_range)
        else $error("slow sensor accepted in window");
    auto_entry_a: assert property (!force_req && !sine_entry_ok |=> !drive_is_sine)
        else $error("sine entered without conditions");
    forced_square_a: assert property (force_req && !force_shape && pwm_output_enable
                                      |=> gate_hi == $past(sq_pwm_hi))
        else $error("forced square path not driven");
    forced_sine_a: assert property (force_req && force_shape |=> drive_is_sine)
        else $error("forced sine not applied");
    shape_square_a: assert property (!force_req && shape_sel |=> !drive_is_sine)
        else $error("square shape ignored");
    debounce_hold_a: assert property ($changed(deb_q[0]) |-> $past(deb_cnt_q[0])
                                      == 8'(DEBOUNCE_CYC - 1))
        else $error("sensor change passed before debounce time");
    reg_off_a: assert property (!reg_en |=> rotor_state == $past(deb_q))
        else $error("regulation off but code filtered");
    reg_gap_a: assert property (reg_en && (deb_q == 3'b000 || deb_q == 3'b111)
                                |=> $stable(rotor_state))
        else $error("illegal sensor code passed");
    invert_a: assert property (deb_cnt_q[0] == 8'h00 && deb_q[0] == 1'b0 && rotor_sensor_q[INV_LSB]
                               && !rotor_sensor_a |=> deb_cnt_q[0] == 8'h01)
        else $error("sensor inversion not applied");
endmodule

// *** sim/mdsr_rotor_model.sv ***
// Rotor sensor model driving the three sensor lines of the block
`timescale 1ns/10ps
module mdsr_rotor_model (
    input  wire logic       clk,    // System clock
    output logic      [2:0] sensor  // Sensor levels {c,b,a}
);
    initial sensor = 3'h0;
    // Hold one sensor code for a number of cycles
    task automatic step(input logic [2:0] code, input int cyc);
        @(posedge clk) sensor <= code;
        repeat (cyc - 1) @(posedge clk);
    endtask
    // Legal six-step rotation, one code per step
    task automatic rotate(input int turns, input int cyc);
        logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
        for (int t = 0; t < turns * 6; t++) begin
            step(seq[t % 6], cyc);
        end
    endtask
endmodule

// *** sim/mdsr_ctl_test.sv ***
// Self-checking bench for the shift and rotor sensing control block
`timescale 1ns/10ps
module mdsr_ctl_test;
    import mdsr_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [4:0] shift_voltage_pin = 5'h00;
    logic       pwm_output_enable = 1'b0;
    logic       sine_entry_ok = 1'b0;
    logic [2:0] sq_hi = 3'h1, sq_lo = 3'h2, sn_hi = 3'h4, sn_lo = 3'h1;
    logic [7:0] reg_rdata;
    logic [2:0] sensor, gate_hi, gate_lo, rotor_state;
    logic [5:0] lead_angle;
    logic       predictor_in_range, drive_is_sine;
    int         n_errors = 0;
    int         checks = 0;
    always #20 clk = ~clk;
    mdsr_rotor_model rotor (.clk(clk), .sensor(sensor));
    mdsr_ctl #(.R0_MAX_CYC(2000), .R0_MIN_CYC(100), .R1_MAX_CYC(5000), .R1_MIN_CYC(700),
               .R2_MAX_CYC(20000), .R2_MIN_CYC(1000)) uut (
        .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rotor_sensor_a(sensor[0]), .rotor_sensor_b(sensor[1]), .rotor_sensor_c(sensor[2]),
        .shift_voltage_pin(shift_voltage_pin), .pwm_output_enable(pwm_output_enable),
        .sine_entry_ok(sine_entry_ok), .sq_pwm_hi(sq_hi), .sq_pwm_lo(sq_lo),
        .sine_pwm_hi(sn_hi), .sine_pwm_lo(sn_lo), .gate_hi(gate_hi), .gate_lo(gate_lo),
        .rotor_state(rotor_state), .lead_angle(lead_angle),
        .predictor_in_range(predictor_in_range), .drive_is_sine(drive_is_sine));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp(what, e, reg_rdata);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] rv [4] = '{PHASE_SHIFT_RST, SINE_DRIVE_RST, ROTOR_SENSOR_RST, PWM_MODE_RST};
        logic [7:0] mk [4] = '{8'hff, SINE_DRIVE_MASK, ROTOR_SENSOR_MASK, PWM_MODE_MASK};
        for (int i = 0; i < 4; i++) begin
            rdc("reset_value", PHASE_SHIFT_ADDR + 8'(i), rv[i]);
            wr(PHASE_SHIFT_ADDR + 8'(i), 8'hff);
            rdc("writable_bits", PHASE_SHIFT_ADDR + 8'(i), mk[i]);
            wr(PHASE_SHIFT_ADDR + 8'(i), 8'h00);
        end
        wr(8'h20, 8'hff);
        rdc("unmapped", 8'h20, 8'h00);
    endtask
    task automatic t_angle;
        logic [4:0] codes [3] = '{5'd0, 5'd16, 5'd31};
        logic [7:0] e;
        foreach (codes[i]) begin
            e = 8'((int'(codes[i]) * int'(ANGLE_MAX_DEG) + 15) / int'(ANGLE_MAX_SET));
            wr(PHASE_SHIFT_ADDR, {3'b100, codes[i]});
            shift_voltage_pin <= ~codes[i];
            cyc(3);
            cmp("lead_angle_field", e, {2'b00, lead_angle});
            wr(PHASE_SHIFT_ADDR, 8'h00);
            shift_voltage_pin <= codes[i];
            cyc(3);
            cmp("lead_angle_pin", e, {2'b00, lead_angle});
        end
    endtask
    task automatic t_forced;
        logic [7:0] eg;
        @(posedge clk);
        sine_entry_ok <= 1'b0;
        pwm_output_enable <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(SINE_DRIVE_ADDR, 8'(m << 6));
            // Square and sine sources differ in every step so a wrong path shows
            sq_hi <= 3'(m);
            sq_lo <= 3'(7 - m);
            sn_hi <= 3'(7 - m);
            sn_lo <= 3'(m);
            cyc(3);
            eg = (m == 3) ? {2'b00, 3'(7 - m), 3'(m)} : {2'b00, 3'(m), 3'(7 - m)};
            cmp("drive_is_sine", {7'h0, m == 3}, {7'h0, drive_is_sine});
            cmp("gates", eg, {2'b00, gate_hi, gate_lo});
        end
    endtask
    task automatic t_min_duty;
        int on;
        int hi;
        @(posedge clk);
        pwm_output_enable <= 1'b0;
        for (int en = 1; en >= 0; en--) begin
            wr(PWM_MODE_ADDR, 8'(en));
            cyc(2);
            on = 0;
            hi = 0;
            repeat (PWM_PER_CYC) begin
                cyc(1);
                on += int'(gate_lo === 3'h7);
                hi += int'(gate_hi !== 3'h0);
            end
            cmp("min_duty_cycles", 8'(en * MIN_ON_CYC), 8'(on));
            cmp("gate_hi_active", 8'h00, 8'(hi));
        end
    endtask
    task automatic t_sensor;
        rotor.step(3'h1, 40);
        #1 cmp("bounce_rejected", 8'h00, {5'h0, rotor_state});
        rotor.step(3'h0, 10);
        // A level held 75 cycles is taken, and shows one cycle later
        rotor.step(3'h1, 76);
        #1 cmp("debounce_early", 8'h00, {5'h0, rotor_state});
        cyc(1);
        cmp("debounce_done", 8'h01, {5'h0, rotor_state});
        rotor.step(3'h0, 100);
        #1 cmp("sensor_released", 8'h00, {5'h0, rotor_state});
        wr(ROTOR_SENSOR_ADDR, 8'h05);
        cyc(80);
        cmp("inverted_code", 8'h05, {5'h0, rotor_state});
        wr(ROTOR_SENSOR_ADDR, 8'h08);
        cyc(80);
        cmp("illegal_held", 8'h05, {5'h0, rotor_state});
        wr(ROTOR_SENSOR_ADDR, 8'h00);
        cyc(80);
        cmp("filter_off", 8'h00, {5'h0, rotor_state});
    endtask
    task automatic t_predict;
        @(posedge clk);
        sine_entry_ok <= 1'b1;
        pwm_output_enable <= 1'b1;
        wr(SINE_DRIVE_ADDR, 8'h00);
        rotor.rotate(3, 100);
        #1 cmp("in_range_slow", 8'h01, {7'h0, predictor_in_range});
        cmp("auto_sine", 8'h01, {7'h0, drive_is_sine});
        rdc("status", DRIVE_STATUS_ADDR, 8'hc5);
        wr(PWM_MODE_ADDR, 8'h80);
        cyc(3);
        cmp("shape_square", 8'h00, {7'h0, drive_is_sine});
        for (int r = 1; r < 3; r++) begin
            wr(PHASE_SHIFT_ADDR, 8'(r << 5));
            rotor.rotate(3, 100);
            #1 cmp("out_of_range", 8'h00, {7'h0, predictor_in_range});
        end
        // A 1200-cycle sensor period lies inside the fast window
        rotor.rotate(2, 200);
        #1 cmp("in_range_fast", 8'h01, {7'h0, predictor_in_range});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(1);
        t_regs;
        t_angle;
        t_forced;
        t_min_duty;
        t_sensor;
        t_predict;
        conclude;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude;
    end
endmodule
